// File: core/bst_params.svh
// Purpose: Named constants of the boundary-scan test port
// Assumes: Included by bare name after the package
// Notes: Definitions only
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH
`define BST_NUM_IOB 8
`define BST_IOB_W 3
`define BST_TMS_IOB 0
`define BST_TCK_IOB 1
`define BST_TDI_IOB 2
`define BST_GCLK_IOB 3
`define BST_ADR_W 4
`define BST_ADR_CTRL 4'h0
`define BST_ADR_STATUS 4'h4
`define BST_CTRL_SCAN_EN 0
`define BST_CTRL_RESET 1'b0
`define BST_ST_TAP_LSB 0
`define BST_ST_TAP_MSB 3
`define BST_ST_IR_LSB 4
`define BST_ST_IR_MSB 6
`define BST_ST_AVAIL 7
`define BST_ST_TAP_EN 8
`define BST_IR_FIXED 2'h1
`define BST_NP_TDO_OE 0
`define BST_NP_TDO_DATA 1
`define BST_NP_VENDOR 2
`define BST_NP_W 3
`endif

// File: core/bst_pkg.sv
// Purpose: Types shared by the boundary-scan test port
// Assumes: Nothing
// Notes: Constants live in bst_params.svh
package bst_pkg;
  typedef enum logic [3:0] {
    st_tlr = 4'h0, st_rti = 4'h1, st_sel_dr = 4'h2, st_cap_dr = 4'h3,
    st_sh_dr = 4'h4, st_ex1_dr = 4'h5, st_pa_dr = 4'h6,
    st_ex2_dr = 4'h7, st_upd_dr = 4'h8, st_sel_ir = 4'h9,
    st_cap_ir = 4'ha, st_sh_ir = 4'hb, st_ex1_ir = 4'hc,
    st_pa_ir = 4'hd, st_ex2_ir = 4'he, st_upd_ir = 4'hf
  } bst_tap_type;

  typedef enum logic [2:0] {
    ins_extest = 3'h0, ins_sample = 3'h1, ins_user1 = 3'h2,
    ins_user2 = 3'h3, ins_readout = 3'h4, ins_load = 3'h5,
    ins_reserved = 3'h6, ins_bypass = 3'h7
  } bst_ins_type;

  // Strobes from the controller to every boundary cell
  typedef struct packed {
    logic capture;
    logic shift;
    logic open;
    logic extest;
    logic io_off;
    logic scan_sel;
  } bst_ctl_type;
endpackage

// File: core/bst_iob_cells.sv
// Purpose: Three boundary cells and update latches of one io_block
// Assumes: Capture and shift strobes are one clk_sys cycle wide
// Notes: Cell 0 is nearest the serial output
`timescale 1ns/100ps
`default_nettype none
`include "bst_params.svh"
module bst_iob_cells #(
  parameter bit IS_TAP_IN = 1'b0,
  parameter bit IS_GCLK = 1'b0
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Sync reset
  input wire bst_pkg::bst_ctl_type ctl, // Controller strobes
  input wire logic sin, // Serial in, far side
  output logic sout, // Serial out, toward TDO
  input wire logic pad_in, // Pin level
  input wire logic core_out, // Logic output data
  input wire logic core_oe, // Logic output enable
  output logic pad_out, // To output buffer
  output logic pad_oe, // To buffer enable
  output logic core_in // To internal logic
);
  import bst_pkg::*;
  typedef struct packed {
    logic meta;
    logic sync;
    logic [`BST_IOB_W-1:0] sh;
    logic [`BST_IOB_W-1:0] up;
  } bst_cell_state_type;
  bst_cell_state_type r, n;

  always_comb begin
    n = r;
    n.meta = pad_in;
    n.sync = r.meta;
    if (ctl.capture) begin
      // Logic values captured too, so EXTEST observes the core
      n.sh = {r.sync, core_out, core_oe};
    end else if (ctl.shift) begin
      n.sh = {sin, r.sh[2:1]};
    end
    if (ctl.open) begin
      n.up = r.sh;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sout = r.sh[0];
  assign pad_out = ctl.extest ? r.up[1] : core_out;
  // Output buffer of a TAP input pad is off whenever the TAP is enabled
  assign pad_oe = (ctl.io_off || (IS_TAP_IN && ctl.scan_sel)) ? 1'b0 :
                  ctl.extest ? r.up[0] : core_oe;
  // Clock pads feed the clock net from the synchronised pin, even in EXTEST
  assign core_in = (ctl.extest && !IS_GCLK) ? r.up[2] : r.sync;
endmodule
`default_nettype wire

// File: core/bst_tap.sv
// Purpose: Boundary-scan TAP, instruction, bypass and boundary chain
// Assumes: TAP pins are slow against clk_sys and are oversampled
// Notes: Registers reached over classic Wishbone
`timescale 1ns/100ps
`default_nettype none
`include "bst_params.svh"
module bst_tap (
  input wire logic clk_sys, // System clock, 250 MHz
  input wire logic rst, // Sync reset, power-up
  input wire logic tck_pin, // Test clock pin
  input wire logic tms_pin, // Test mode select pin
  input wire logic tdi_pin, // Test data in pin
  output logic tdo_out, // Test data out level
  output logic tdo_oe, // Test data out enable
  input wire logic reprogram_n, // Reprogram pin, low active
  input wire logic cfg_busy, // Configuration in progress
  input wire logic cfg_done, // Configuration finished
  input wire logic cfg_daisy_out, // Configuration daisy output
  input wire logic readback_data, // Configuration readout data
  input wire logic first_user_serial_return, // User 1 return
  input wire logic second_user_serial_return, // User 2 return
  output logic first_user_select, // User 1 selected
  output logic second_user_select, // User 2 selected
  input wire logic [`BST_NUM_IOB-1:0] pad_in, // Pin levels
  input wire logic [`BST_NUM_IOB-1:0] core_out, // Logic data
  input wire logic [`BST_NUM_IOB-1:0] core_oe, // Logic enables
  output logic [`BST_NUM_IOB-1:0] pad_out, // Output buffers
  output logic [`BST_NUM_IOB-1:0] pad_oe, // Buffer enables
  output logic [`BST_NUM_IOB-1:0] core_in, // Inputs to logic
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [`BST_ADR_W-1:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o // Acknowledge
);
  import bst_pkg::*;

  typedef struct packed {
    logic tck_meta;
    logic tck_sync;
    logic tck_prev;
    logic tms_meta;
    logic tms_sync;
    logic tdi_meta;
    logic tdi_sync;
    logic prg_meta;
    logic prg_sync;
    bst_tap_type state;
    bst_ins_type ir;
    logic [2:0] ir_sh;
    logic bypass;
    logic [`BST_NP_W-1:0] np_sh;
    logic [`BST_NP_W-1:0] np_up;
    logic tdo;
    logic tdo_en;
    logic scan_en;
    logic ack;
    logic [31:0] dat;
  } bst_core_state_type;

  bst_core_state_type r, n;
  bst_ctl_type ctl;
  logic tck_rise;
  logic tck_fall;
  logic tap_en;
  logic avail;
  logic wb_req;
  bst_ins_type ins_eff;
  logic dr_out;
  logic tdo_src;
  logic [`BST_NUM_IOB:0] chain;

  // Decoded TAP state and register bus qualifiers
  logic in_tlr;
  logic in_cap_dr;
  logic in_sh_dr;
  logic in_upd_dr;
  logic in_sh_ir;
  logic in_upd_ir;
  logic tap_hold;
  logic wb_take;
  logic wb_wr_ctrl;
  logic [2:0] ir_capture;
  logic [31:0] rd_word;

  // Standard TAP transition function
  function automatic bst_tap_type tap_next(input bst_tap_type s,
                                            input logic tms);
    bst_tap_type t;
    t = s;
    unique case (s)
      st_tlr: t = tms ? st_tlr : st_rti;
      st_rti: t = tms ? st_sel_dr : st_rti;
      st_sel_dr: t = tms ? st_sel_ir : st_cap_dr;
      st_cap_dr: t = tms ? st_ex1_dr : st_sh_dr;
      st_sh_dr: t = tms ? st_ex1_dr : st_sh_dr;
      st_ex1_dr: t = tms ? st_upd_dr : st_pa_dr;
      st_pa_dr: t = tms ? st_ex2_dr : st_pa_dr;
      st_ex2_dr: t = tms ? st_upd_dr : st_sh_dr;
      st_upd_dr: t = tms ? st_sel_dr : st_rti;
      st_sel_ir: t = tms ? st_tlr : st_cap_ir;
      st_cap_ir: t = tms ? st_ex1_ir : st_sh_ir;
      st_sh_ir: t = tms ? st_ex1_ir : st_sh_ir;
      st_ex1_ir: t = tms ? st_upd_ir : st_pa_ir;
      st_pa_ir: t = tms ? st_ex2_ir : st_pa_ir;
      st_ex2_ir: t = tms ? st_upd_ir : st_sh_ir;
      st_upd_ir: t = tms ? st_sel_dr : st_rti;
    endcase
    return t;
  endfunction

  // Edges found on the second synchroniser stage only
  assign tck_rise = r.tck_sync & ~r.tck_prev;
  assign tck_fall = ~r.tck_sync & r.tck_prev;
  assign tap_en = ~cfg_done | r.scan_en;
  assign avail = ~cfg_busy;
  assign wb_req = wb_cyc_i & wb_stb_i;
  // New request only; the acked cycle must not capture again
  assign wb_take = wb_req & ~r.ack;
  // Write lands at the edge where the master sees ack
  assign wb_wr_ctrl = wb_req & r.ack & wb_we_i & wb_sel_i[0] &
                      (wb_adr_i == `BST_ADR_CTRL);
  // Reprogram low, or scan switched off once configuration is done, parks the TAP
  assign tap_hold = ~r.prg_sync | ~tap_en;
  // Status word: I0 one, I1 zero, availability on top
  assign ir_capture = {avail, `BST_IR_FIXED};

  // State decodes shared by strobes, shifts and TDO control
  assign in_tlr = r.state == st_tlr;
  assign in_cap_dr = r.state == st_cap_dr;
  assign in_sh_dr = r.state == st_sh_dr;
  assign in_upd_dr = r.state == st_upd_dr;
  assign in_sh_ir = r.state == st_sh_ir;
  assign in_upd_ir = r.state == st_upd_ir;

  // During configuration only sample, bypass and load stay usable
  always_comb begin
    ins_eff = r.ir;
    if (cfg_busy && r.ir != ins_sample && r.ir != ins_bypass &&
        r.ir != ins_load) begin
      ins_eff = ins_bypass;
    end
  end

  // Strobes for all boundary cells; shift ignores the instruction
  always_comb begin
    ctl.capture = tck_rise && in_cap_dr;
    ctl.shift = tck_rise && in_sh_dr;
    ctl.open = in_upd_dr && ~r.tck_sync;
    ctl.extest = tap_en && ins_eff == ins_extest;
    ctl.io_off = tap_en && ins_eff == ins_load;
    ctl.scan_sel = tap_en;
  end

  // Chain: TDO cells, io_blocks 0..N-1, vendor cell, TDI
  assign chain[`BST_NUM_IOB] = r.np_sh[`BST_NP_VENDOR];
  assign dr_out = r.np_sh[`BST_NP_TDO_OE];

  genvar k;
  generate
    for (k = 0; k < `BST_NUM_IOB; k++) begin : g_iob
      // Every io_block kept, used or not
      bst_iob_cells #(
        .IS_TAP_IN(k == `BST_TMS_IOB || k == `BST_TCK_IOB ||
                   k == `BST_TDI_IOB),
        .IS_GCLK(k == `BST_GCLK_IOB)
      ) i_bst_iob_cells (
        .clk_sys(clk_sys),
        .rst(rst),
        .ctl(ctl),
        .sin(chain[k+1]),
        .sout(chain[k]),
        .pad_in(pad_in[k]),
        .core_out(core_out[k]),
        .core_oe(core_oe[k]),
        .pad_out(pad_out[k]),
        .pad_oe(pad_oe[k]),
        .core_in(core_in[k])
      );
    end
  endgenerate

  // Serial source ahead of the falling-edge flop
  always_comb begin
    tdo_src = r.bypass;
    if (in_sh_ir) begin
      tdo_src = r.ir_sh[0];
    end else begin
      unique case (ins_eff)
        ins_extest: tdo_src = dr_out;
        ins_sample: tdo_src = dr_out;
        ins_user1: tdo_src = first_user_serial_return;
        ins_user2: tdo_src = second_user_serial_return;
        ins_readout: tdo_src = readback_data;
        ins_load: tdo_src = cfg_daisy_out;
        ins_reserved: tdo_src = r.bypass;
        ins_bypass: tdo_src = r.bypass;
      endcase
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_word = '0;
    case (wb_adr_i)
      `BST_ADR_CTRL: begin
        rd_word[`BST_CTRL_SCAN_EN] = r.scan_en;
      end
      `BST_ADR_STATUS: begin
        rd_word[`BST_ST_TAP_MSB:`BST_ST_TAP_LSB] = r.state;
        rd_word[`BST_ST_IR_MSB:`BST_ST_IR_LSB] = r.ir;
        rd_word[`BST_ST_AVAIL] = avail;
        rd_word[`BST_ST_TAP_EN] = tap_en;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  always_comb begin
    n = r;
    // TAP pins feed the controller directly, never scan data
    n.tck_meta = tck_pin;
    n.tck_sync = r.tck_meta;
    n.tck_prev = r.tck_sync;
    n.tms_meta = tms_pin;
    n.tms_sync = r.tms_meta;
    n.tdi_meta = tdi_pin;
    n.tdi_sync = r.tdi_meta;
    n.prg_meta = reprogram_n;
    n.prg_sync = r.prg_meta;

    // Capture and shift on the synchronised TCK rise
    if (tck_rise) begin
      n.state = tap_next(r.state, r.tms_sync);
      unique case (r.state)
        st_cap_ir: n.ir_sh = ir_capture;
        st_sh_ir: n.ir_sh = {r.tdi_sync, r.ir_sh[2:1]};
        st_cap_dr: begin
          n.bypass = 1'b0;
          n.np_sh[`BST_NP_TDO_OE] = r.tdo_en;
          n.np_sh[`BST_NP_TDO_DATA] = r.tdo;
          n.np_sh[`BST_NP_VENDOR] = 1'b0;
        end
        st_sh_dr: begin
          n.bypass = r.tdi_sync;
          n.np_sh[`BST_NP_TDO_OE] = r.np_sh[`BST_NP_TDO_DATA];
          n.np_sh[`BST_NP_TDO_DATA] = chain[0];
          n.np_sh[`BST_NP_VENDOR] = r.tdi_sync;
        end
        default: n.np_sh = r.np_sh;
      endcase
    end

    // Latch follows while open and holds through the next shift
    if (ctl.open) begin
      n.np_up = r.np_sh;
    end

    // Launch on the fall, so the tester samples a settled bit
    if (tck_fall) begin
      if (in_upd_ir) begin
        n.ir = bst_ins_type'(r.ir_sh);
      end
      n.tdo = tdo_src;
      n.tdo_en = in_sh_ir || in_sh_dr;
    end

    if (in_tlr) begin
      n.ir = ins_bypass;
    end

    // Held in reset while reprogramming or when scan is switched off once configuration is done
    if (tap_hold) begin
      n.state = st_tlr;
      n.ir = ins_bypass;
      n.tdo_en = 1'b0;
    end

    // Wishbone: ack one cycle after the request, write at the edge after ack rises
    n.ack = wb_take;
    if (wb_take) begin
      n.dat = rd_word;
    end
    if (wb_wr_ctrl) begin
      n.scan_en = wb_dat_i[`BST_CTRL_SCAN_EN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '0;
      r.state <= st_tlr;
      r.ir <= ins_bypass;
      r.prg_meta <= 1'b1;
      r.prg_sync <= 1'b1;
      r.scan_en <= `BST_CTRL_RESET;
    end else begin
      r <= n;
    end
  end

  // Both TDO outputs come from flops, so the pad never glitches
  assign tdo_out = r.tdo;
  assign tdo_oe = r.tdo_en;
  assign first_user_select = tap_en && ins_eff == ins_user1;
  assign second_user_select = tap_en && ins_eff == ins_user2;
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
endmodule
`default_nettype wire

// File: bench/bst_tap_asserts.sv
// Purpose: Port checks of bst_tap
// Assumes: Bound to bst_tap
// Notes: TAP pins are oversampled, so TDO lags the TCK fall
`timescale 1ns/100ps
`default_nettype none
`include "bst_params.svh"
module bst_tap_asserts (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic tck_pin, // Test clock
  input wire logic reprogram_n, // Reprogram
  input wire logic cfg_done, // Configured
  input wire logic tdo_out, // TDO level
  input wire logic tdo_oe, // TDO enable
  input wire logic first_user_select, // User 1
  input wire logic second_user_select, // User 2
  input wire logic [`BST_NUM_IOB-1:0] pad_in, // Pins
  input wire logic [`BST_NUM_IOB-1:0] core_out, // Logic data
  input wire logic [`BST_NUM_IOB-1:0] core_oe, // Logic enables
  input wire logic [`BST_NUM_IOB-1:0] pad_out, // Buffers
  input wire logic [`BST_NUM_IOB-1:0] pad_oe, // Buffer enables
  input wire logic [`BST_NUM_IOB-1:0] core_in, // To logic
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_ack_o // Acknowledge
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rst;
    disable iff (1'b0) rst |=> !tdo_oe && !wb_ack_o && !first_user_select;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_rpg; !reprogram_n [*6] |-> !tdo_oe && !second_user_select;
  endproperty
  a_rpg: assert property (p_rpg) else $error("reprogram ignored");
  // Sync plus edge detect: a change lands 3 cycles after the fall
  property p_tdo; $changed(tdo_out) |-> !$past(tck_pin, 3); endproperty
  a_tdo: assert property (p_tdo) else $error("TDO off TCK fall");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pls; wb_ack_o |=> !wb_ack_o; endproperty
  a_pls: assert property (p_pls) else $error("ack too long");
  property p_pad; !cfg_done |-> pad_oe[2:0] == 3'h0; endproperty
  a_pad: assert property (p_pad) else $error("TAP pad driven");
  property p_gck; $stable(pad_in[3]) [*6] |-> core_in[3] == pad_in[3];
  endproperty
  a_gck: assert property (p_gck) else $error("clock overridden");
  property p_usr; first_user_select || second_user_select |->
    pad_out[7:4] == core_out[7:4] && pad_oe[7:4] == core_oe[7:4];
  endproperty
  a_usr: assert property (p_usr) else $error("user I/O replaced");
  c_user: cover property (first_user_select);
  c_oe: cover property ($rose(tdo_oe));
  c_rpg: cover property (!reprogram_n [*6]);
endmodule
`default_nettype wire

// File: bench/bst_tester.sv
// Purpose: Board test controller driving the scan port
// Assumes: clk_sys paces the link, 4 cycles per TCK phase
// Notes: TCK idles low; idle TDI toggles so stale data shows
`timescale 1ns/100ps
`default_nettype none
module bst_tester (
  input wire logic clk_sys, // Pacing clock
  output logic tck, // Test clock
  output logic tms, // Mode select
  output logic tdi, // Serial data out
  input wire logic tdo_out, // Serial data in
  input wire logic tdo_oe // Device drives TDO
);
  logic oe_seen;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk_sys);
    tck <= 1'b1;
    repeat (4) @(posedge clk_sys);
    q = tdo_oe ? tdo_out : 1'b1; // Pulled up while released
    tck <= 1'b0;
  endtask
  task automatic idle(input logic m);
    logic q;
    step(m, ~tdi, q);
  endtask
  // From Run-Test/Idle through one scan and back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    idle(1'b1);
    if (ir) idle(1'b1);
    idle(1'b0);
    idle(1'b0);
    oe_seen = 1'b1;
    for (int i = 0; i < n; i++) begin
      step(logic'(i == n - 1), din[i], b);
      dout[i] = b;
      oe_seen &= tdo_oe;
    end
    idle(1'b1);
    idle(1'b0);
  endtask
endmodule
`default_nettype wire

// File: bench/bst_tap_tb.sv
// Purpose: Self-checking bench of bst_tap
// Assumes: bst_tester drives the TAP pins
// Notes: EXTEST data is judged on io_blocks 4 to 7 only
`timescale 1ns/100ps
`default_nettype none
`include "bst_params.svh"
module bst_tap_tb;
  import bst_pkg::*;
  logic clk_sys, rst, tck_pin, tms_pin, tdi_pin, tdo_out, tdo_oe;
  logic reprogram_n, cfg_busy, cfg_done, cfg_daisy_out, readback_data;
  logic first_user_serial_return, second_user_serial_return;
  logic first_user_select, second_user_select;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [`BST_NUM_IOB-1:0] pad_in, core_out, core_oe, pad_out, pad_oe;
  logic [`BST_NUM_IOB-1:0] core_in, eo, ed, ei;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, e, pre;
  int err_total, checks_done;
  bst_tap i_bst_tap (.clk_sys, .rst, .tck_pin, .tms_pin, .tdi_pin, .tdo_out,
    .tdo_oe, .reprogram_n, .cfg_busy, .cfg_done, .cfg_daisy_out,
    .readback_data, .first_user_serial_return, .second_user_serial_return,
    .first_user_select, .second_user_select, .pad_in, .core_out, .core_oe,
    .pad_out, .pad_oe, .core_in, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  bst_tester i_bst_tester (.clk_sys, .tck(tck_pin), .tms(tms_pin),
    .tdi(tdi_pin), .tdo_out, .tdo_oe);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic ld_ir(input logic [2:0] c);
    i_bst_tester.scan(1'b1, 3, {29'h0, c}, q);
  endtask
  task automatic dr(input int n, input logic [31:0] d);
    i_bst_tester.scan(1'b0, n, d, q);
  endtask
  task automatic tap_reset();
    repeat (5) i_bst_tester.idle(1'b1);
    i_bst_tester.idle(1'b0);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {rst, reprogram_n, cfg_busy, cfg_done} <= 4'hc;
    {cfg_daisy_out, readback_data, first_user_serial_return} <= 3'h0;
    {second_user_serial_return, wb_cyc_i, wb_stb_i, wb_we_i} <= 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {4'h0, 4'hf, 32'h0};
    {pad_in, core_out, core_oe} <= {8'h9e, 8'h5a, 8'hc3};
    pre = 32'h06d9_94e4;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    wb(1'b0, `BST_ADR_STATUS, 32'h0);
    chk(q, 32'h0000_01f0);
    wb(1'b0, `BST_ADR_CTRL, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    tap_reset();
    ld_ir(ins_bypass);
    chk(q, 32'h5);
    chk({31'h0, i_bst_tester.oe_seen}, 32'h1);
    chk({31'h0, tdo_oe}, 32'h0);
    cfg_busy <= 1'b1;
    ld_ir(ins_bypass);
    chk(q, 32'h1);
    cfg_busy <= 1'b0;
    dr(8, 32'ha5);
    chk(q, 32'h4a);
    $display("test reset, status and bypass ended");
    e = 32'h0;
    for (int i = 0; i < 8; i++) begin
      e[2 + 3 * i +: 3] = {pad_in[i], core_out[i], core_oe[i]};
      {ei[i], ed[i], eo[i]} = pre[2 + 3 * i +: 3];
    end
    ld_ir(ins_sample);
    dr(27, pre);
    chk(q & 32'h07ff_fffc, e);
    ld_ir(ins_extest);
    q = {8'h0, pad_oe, pad_out, core_in} & 32'h00f0_f0f0;
    chk(q, {8'h0, eo, ed, ei} & 32'h00f0_f0f0);
    chk({28'h0, pad_oe[2:0], core_in[3]}, {31'h0, pad_in[3]});
    dr(27, pre);
    chk(q & 32'h07ff_fffc, e);
    $display("test preload and external drive ended");
    for (int c = 2; c < 7; c++) begin
      {cfg_daisy_out, readback_data, second_user_serial_return,
        first_user_serial_return} <= 4'h1 << (c - 2);
      ld_ir(c[2:0]);
      q = {30'h0, first_user_select, second_user_select};
      chk(q, {30'h0, c == 2, c == 3});
      if (c == 5) chk(32'(pad_oe), 32'h0);
      dr(8, (c == 6) ? 32'ha5 : 32'h0);
      chk(q & 32'hfe, (c == 6) ? 32'h4a : 32'hfe);
    end
    $display("test output sources ended");
    ld_ir(ins_user2);
    chk({31'h0, second_user_select}, 32'h1);
    reprogram_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    reprogram_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wb(1'b0, `BST_ADR_STATUS, 32'h0);
    chk(q, 32'h0000_01f0);
    cfg_done <= 1'b1;
    repeat (2) @(posedge clk_sys);
    wb(1'b0, `BST_ADR_STATUS, 32'h0);
    chk(q, 32'h0000_00f0);
    tap_reset();
    ld_ir(ins_sample);
    chk({31'h0, i_bst_tester.oe_seen}, 32'h0);
    wb(1'b1, `BST_ADR_CTRL, 32'h1);
    wb(1'b0, `BST_ADR_STATUS, 32'h0);
    chk(q, 32'h0000_01f0);
    tap_reset();
    ld_ir(ins_bypass);
    chk(q, 32'h5);
    $display("test reprogram and enable ended");
    complete_run();
  end
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
endmodule
bind bst_tap bst_tap_asserts i_bst_tap_asserts (.clk_sys, .rst, .tck_pin,
  .reprogram_n, .cfg_done, .tdo_out, .tdo_oe, .first_user_select,
  .second_user_select, .pad_in, .core_out, .core_oe, .pad_out, .pad_oe,
  .core_in, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
`default_nettype wire
